/* rtl/clock_gear_output_control.sv */
// clock fanout control: mode, pair enables, power, gear ratio, serial byte 0
`timescale 1ns/10ps
`include "gear_cfg.svh"

// What this block does
// - bypass pin low fanout, high zero-delay PLL
// - bypass pin also gives slave address bit 2
// - each pair enable low drives, high tri-states
// - one enable drives or tri-states pairs 10, 11
// - power-down high stops clocks, PLL, oscillator
// - frequency range taken from frequency-select input
// - in zero-delay mode output frequency is input times n/m
// - byte 0 bits 3:0 plus select choose m, n
// - power-up gear code is 1:1 for select level

module clock_gear_output_control
   import gear_pkg::*;
(
   // system
   input wire logic clk,
   input wire logic rst,
   // configuration pins
   input wire logic bypass_mode_addr_pin,
   input wire logic addr_bit0_pin,
   input wire logic addr_bit1_pin,
   input wire logic powergood_powerdown_pin,
   input wire logic freq_range_select,
   // output enables, active low
   input wire logic [5:0] pairs0_5_enable_n,
   input wire logic pair6_enable_n,
   input wire logic pair7_enable_n,
   input wire logic pair8_enable_n,
   input wire logic pair9_enable_n,
   input wire logic upper_pairs_enable_n,
   // serial management bus
   input wire logic smbclk_in,
   input wire logic smbdat_in,
   output logic smbdat_out,
   output logic smbdat_oe,
   // clock outputs
   output logic [11:0] diff_clock_pair,
   output logic [11:0] pair_drive,
   // status and analog controls
   output logic zero_delay_mode,
   output logic pll_run,
   output logic osc_run,
   output logic config_ready,
   output logic powered_down,
   output logic [3:0] gear_m,
   output logic [2:0] gear_n
);

   ctrl_st_t q;
   ctrl_st_t d;
   logic [7:0] rx_byte;
   logic byte_done;
   logic bus_start;
   logic bus_stop;
   logic master_nack;
   logic [11:0] drive_w;
   logic [4:0] sum;
   logic [4:0] modulus;
   logic addr_hit;
   logic src_clk;

   // ------------------------------------------------------------
   // gear table
   // ------------------------------------------------------------
   function automatic gear_pair_t gear_lookup(input logic fs, input logic [3:0] code);
      gear_pair_t g;
      g = '{m: 4'd1, n: 3'd1};
      unique case (code)
         4'h0: g = '{m: 4'd3, n: 3'd1};
         4'h1: g = '{m: 4'd5, n: 3'd2};
         4'h2: g = '{m: 4'd12, n: 3'd5};
         4'h3: g = '{m: 4'd2, n: 3'd1};
         4'h4: g = '{m: 4'd5, n: 3'd3};
         4'h5: g = '{m: 4'd8, n: 3'd5};
         4'h6: g = '{m: 4'd3, n: 3'd2};
         4'h7: g = fs ? '{m: 4'd5, n: 3'd4} : '{m: 4'd4, n: 3'd3};
         4'h8: g = '{m: 4'd6, n: 3'd5};
         4'h9: g = '{m: 4'd1, n: 3'd1};
         4'ha: g = '{m: 4'd5, n: 3'd6};
         4'hb: g = '{m: 4'd4, n: 3'd5};
         4'hc: g = '{m: 4'd3, n: 3'd4};
         4'hd: g = '{m: 4'd2, n: 3'd3};
         4'he: g = '{m: 4'd3, n: 3'd5};
         4'hf: g = '{m: 4'd1, n: 3'd2};
      endcase
      return g;
   endfunction

   // ------------------------------------------------------------
   // per-pair enables
   // ------------------------------------------------------------
   genvar i;
   generate
      for (i = 0; i < 12; i++)
      begin : g_pair
         if (i < 10)
         begin : g_own
            assign drive_w[i] = q.ready & ~q.oe_s2[i];
         end
         else
         begin : g_shared
            assign drive_w[i] = q.ready & ~q.oe_s2[10];
         end
      end
   endgenerate

   // ------------------------------------------------------------
   // serial byte engine
   // ------------------------------------------------------------
   smbus_byte_engine u_engine (
      .clk(clk),
      .rst(rst),
      .smbclk_in(smbclk_in),
      .smbdat_in(smbdat_in),
      .smbdat_out(smbdat_out),
      .smbdat_oe(smbdat_oe),
      .ack_en(q.ack_en),
      .tx_mode(q.tx_mode),
      .tx_byte(q.tx_byte),
      .rx_byte(rx_byte),
      .byte_done(byte_done),
      .bus_start(bus_start),
      .bus_stop(bus_stop),
      .master_nack(master_nack)
   );

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb
   begin
      d = q;
      d.pd_sync = {q.pd_sync[0], powergood_powerdown_pin};
      d.fs_sync = {q.fs_sync[0], freq_range_select};
      d.byp_sync = {q.byp_sync[0], bypass_mode_addr_pin};
      d.a0_sync = {q.a0_sync[0], addr_bit0_pin};
      d.a1_sync = {q.a1_sync[0], addr_bit1_pin};
      d.oe_s1 = {upper_pairs_enable_n, pair9_enable_n, pair8_enable_n,
                 pair7_enable_n, pair6_enable_n, pairs0_5_enable_n};
      d.oe_s2 = q.oe_s1;

      // power: first low level is power-good, any later high is power-down
      if (!q.pd_sync[1] && !q.pg_seen)
      begin
         d.pg_seen = 1'b1;
         d.gear_reg = q.fs_sync[1] ? `GEAR_RESET_FS1 : `GEAR_RESET_FS0;
      end
      d.ready = d.pg_seen & ~q.pd_sync[1];
      // pin is synchronised and registered, so power-down reacts three cycles late
      d.powered_down = q.pg_seen & q.pd_sync[1];
      d.osc_run = d.ready;
      d.zero_delay = q.byp_sync[1];
      d.pll_run = d.ready & q.byp_sync[1];
      d.gear = gear_lookup(q.fs_sync[1], q.gear_reg[`GEAR_CODE_MSB:`GEAR_CODE_LSB]);

      // rate generator: ref is clk/4, gear toggles n times per 2m cycles
      sum = q.acc + {2'b00, q.gear.n};
      modulus = {q.gear.m, 1'b0};
      if (!q.ready)
      begin
         d.acc = 5'd0;
         d.gear_clk = 1'b0;
         d.ref_clk = 1'b0;
         d.ref_div = 1'b0;
      end
      else
      begin
         d.ref_div = ~q.ref_div;
         if (q.ref_div)
         begin
            d.ref_clk = ~q.ref_clk;
         end
         if (sum >= modulus)
         begin
            d.acc = sum - modulus;
            d.gear_clk = ~q.gear_clk;
         end
         else
         begin
            d.acc = sum;
         end
      end
      src_clk = q.zero_delay ? q.gear_clk : q.ref_clk;
      d.pair_drive = drive_w;
      d.pair_clk = drive_w & {12{src_clk}};

      // byte protocol
      addr_hit = rx_byte[7:1] == {`SMB_ADDR_HI, q.byp_sync[1], q.a1_sync[1], q.a0_sync[1]};
      if (bus_stop)
      begin
         d.st = ST_IDLE;
         d.tx_mode = 1'b0;
         d.ack_en = 1'b0;
      end
      else if (bus_start)
      begin
         d.st = ST_ADDR;
         d.tx_mode = 1'b0;
         d.ack_en = 1'b0;
      end
      else if (byte_done)
      begin
         unique case (q.st)
            ST_ADDR:
            begin
               d.ack_en = addr_hit;
               if (!addr_hit)
               begin
                  d.st = ST_IGNORE;
               end
               else if (rx_byte[0])
               begin
                  d.st = ST_RDATA;
                  d.tx_mode = 1'b1;
                  d.tx_byte = `READ_BYTE_COUNT;
               end
               else
               begin
                  d.st = ST_CMD;
               end
            end
            ST_CMD:
            begin
               d.index = rx_byte;
               d.st = ST_COUNT;
            end
            ST_COUNT:
            begin
               d.count = rx_byte;
               d.st = ST_WDATA;
            end
            ST_WDATA:
            begin
               if (q.count != 8'h00)
               begin
                  if (q.index == `GEAR_REG_OFFSET)
                  begin
                     d.gear_reg = rx_byte;
                  end
                  d.count = q.count - 8'h01;
                  d.index = q.index + 8'h01;
               end
            end
            ST_RDATA:
            begin
               if (master_nack)
               begin
                  d.st = ST_IGNORE;
                  d.tx_mode = 1'b0;
               end
               else
               begin
                  d.tx_byte = (q.index == `GEAR_REG_OFFSET) ? q.gear_reg : `UNMAPPED_READ;
                  d.index = q.index + 8'h01;
               end
            end
            ST_IDLE, ST_IGNORE:
            begin
               d.ack_en = 1'b0;
            end
            default:
            begin
               d.st = ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         q <= '0;
         q.gear_reg <= `GEAR_RESET_FS0;
         q.gear <= '{m: 4'd1, n: 3'd1};
         q.pd_sync <= 2'b11;
         q.oe_s1 <= '1;
         q.oe_s2 <= '1;
      end
      else
      begin
         q <= d;
      end
   end

   assign diff_clock_pair = q.pair_clk;
   assign pair_drive = q.pair_drive;
   assign zero_delay_mode = q.zero_delay;
   assign pll_run = q.pll_run;
   assign osc_run = q.osc_run;
   assign config_ready = q.ready;
   assign powered_down = q.powered_down;
   assign gear_m = q.gear.m;
   assign gear_n = q.gear.n;

endmodule

/* rtl/gear_cfg.svh */
// constants for the clock gear and output control block
`ifndef GEAR_CFG_SVH
`define GEAR_CFG_SVH

// register map
`define GEAR_REG_OFFSET 8'h00
`define GEAR_CODE_MSB 3
`define GEAR_CODE_LSB 0

// power-up value of the gear byte, per frequency-select level (1:1 code)
`define GEAR_RESET_FS0 8'h09
`define GEAR_RESET_FS1 8'h09

// serial slave address: upper four bits fixed, lower three from pins
`define SMB_ADDR_HI 4'hd

// byte count returned first in a block read
`define READ_BYTE_COUNT 8'h01

// value read from unmapped byte locations
`define UNMAPPED_READ 8'h00

`endif

/* rtl/gear_pkg.sv */
// types shared by the clock gear control and its serial byte engine
package gear_pkg;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_ADDR = 3'b001,
      ST_CMD = 3'b010,
      ST_COUNT = 3'b011,
      ST_WDATA = 3'b100,
      ST_RDATA = 3'b101,
      ST_IGNORE = 3'b110
   } bus_st_t;

   typedef struct packed {
      logic [3:0] m;
      logic [2:0] n;
   } gear_pair_t;

   typedef struct packed {
      logic [1:0] scl_sync;
      logic [1:0] sda_sync;
      logic scl_prev;
      logic sda_prev;
      logic active;
      logic dir;
      logic [3:0] bit_cnt;
      logic [7:0] shift;
      logic sda_out;
      logic sda_oe;
      logic byte_done;
      logic start;
      logic stop;
      logic nack;
   } engine_st_t;

   typedef struct packed {
      logic [1:0] pd_sync;
      logic [1:0] fs_sync;
      logic [1:0] byp_sync;
      logic [1:0] a0_sync;
      logic [1:0] a1_sync;
      logic [10:0] oe_s1;
      logic [10:0] oe_s2;
      logic pg_seen;
      logic ready;
      logic powered_down;
      logic zero_delay;
      logic pll_run;
      logic osc_run;
      logic [7:0] gear_reg;
      gear_pair_t gear;
      bus_st_t st;
      logic [7:0] index;
      logic [7:0] count;
      logic ack_en;
      logic tx_mode;
      logic [7:0] tx_byte;
      logic [4:0] acc;
      logic gear_clk;
      logic ref_clk;
      logic ref_div;
      logic [11:0] pair_drive;
      logic [11:0] pair_clk;
   } ctrl_st_t;

endpackage

/* rtl/smbus_byte_engine.sv */
// serial management bus slave: bit timing, start/stop, byte shift, ack
`timescale 1ns/10ps
`include "gear_cfg.svh"

module smbus_byte_engine
   import gear_pkg::*;
(
   // system
   input wire logic clk,
   input wire logic rst,
   // serial pins
   input wire logic smbclk_in,
   input wire logic smbdat_in,
   output logic smbdat_out,
   output logic smbdat_oe,
   // byte side
   input wire logic ack_en,
   input wire logic tx_mode,
   input wire logic [7:0] tx_byte,
   output logic [7:0] rx_byte,
   output logic byte_done,
   output logic bus_start,
   output logic bus_stop,
   output logic master_nack
);

   engine_st_t q;
   engine_st_t d;
   logic scl_hi;
   logic scl_rise;
   logic scl_fall;
   logic sda_rise;
   logic sda_fall;

   always_comb
   begin
      d = q;
      d.scl_sync = {q.scl_sync[0], smbclk_in};
      d.sda_sync = {q.sda_sync[0], smbdat_in};
      d.scl_prev = q.scl_sync[1];
      d.sda_prev = q.sda_sync[1];
      d.byte_done = 1'b0;
      d.start = 1'b0;
      d.stop = 1'b0;
      d.nack = 1'b0;
      d.sda_out = 1'b0;
      scl_hi = q.scl_sync[1] & q.scl_prev;
      scl_rise = q.scl_sync[1] & ~q.scl_prev;
      scl_fall = ~q.scl_sync[1] & q.scl_prev;
      sda_rise = q.sda_sync[1] & ~q.sda_prev;
      sda_fall = ~q.sda_sync[1] & q.sda_prev;
      if (scl_hi && sda_fall)
      begin
         // repeated start lands here too and restarts the address byte
         d.active = 1'b1;
         d.dir = 1'b0;
         // the start's own scl fall wraps this to zero before the first bit
         d.bit_cnt = 4'hf;
         d.start = 1'b1;
      end
      else if (scl_hi && sda_rise)
      begin
         d.active = 1'b0;
         d.stop = 1'b1;
      end
      else if (q.active && scl_rise)
      begin
         if (q.bit_cnt == 4'd8)
         begin
            if (q.dir)
            begin
               d.nack = q.sda_sync[1];
               d.byte_done = 1'b1;
            end
         end
         else if (!q.dir)
         begin
            d.shift = {q.shift[6:0], q.sda_sync[1]};
         end
      end
      else if (q.active && scl_fall)
      begin
         if (q.bit_cnt == 4'd8)
         begin
            // direction is fixed per byte so an address ack is never lost
            d.bit_cnt = 4'd0;
            d.dir = tx_mode;
            if (tx_mode)
            begin
               d.shift = tx_byte;
            end
         end
         else
         begin
            d.bit_cnt = q.bit_cnt + 4'd1;
            if (q.dir)
            begin
               d.shift = {q.shift[6:0], 1'b0};
            end
            else if (q.bit_cnt == 4'd7)
            begin
               d.byte_done = 1'b1;
            end
         end
      end
      // open drain: only ever pull low, changes follow scl falling
      d.sda_oe = d.active && ((d.bit_cnt < 4'd8 && d.dir && !d.shift[7])
                 || (d.bit_cnt == 4'd8 && !d.dir && ack_en));
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         q <= '0;
      end
      else
      begin
         q <= d;
      end
   end

   assign smbdat_out = q.sda_out;
   assign smbdat_oe = q.sda_oe;
   assign rx_byte = q.shift;
   assign byte_done = q.byte_done;
   assign bus_start = q.start;
   assign bus_stop = q.stop;
   assign master_nack = q.nack;

endmodule

/* test/clock_gear_output_control_bench.sv */
// self-checking bench for the clock gear output control
`timescale 1ns/10ps
module clock_gear_output_control_bench;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic bypass_mode_addr_pin = 1'b0;
   logic addr_bit0_pin = 1'b0;
   logic addr_bit1_pin = 1'b0;
   logic powergood_powerdown_pin = 1'b1;
   logic freq_range_select = 1'b0;
   logic [5:0] pairs0_5_enable_n = 6'h3f;
   logic pair6_enable_n = 1'b1;
   logic pair7_enable_n = 1'b1;
   logic pair8_enable_n = 1'b1;
   logic pair9_enable_n = 1'b1;
   logic upper_pairs_enable_n = 1'b1;
   logic smbclk_in, smbdat_in, smbdat_out, smbdat_oe, sda_drv;
   logic [11:0] diff_clock_pair, pair_drive;
   logic zero_delay_mode, pll_run, osc_run, config_ready, powered_down;
   logic [3:0] gear_m;
   logic [2:0] gear_n;
   logic [31:0] seed = 32'ha214;
   logic [7:0] cnt, rd, wd;
   logic ack;
   logic [3:0] gm;
   logic [2:0] gn;
   int tog;
   int n_mismatch = 0;
   int n_compared = 0;
   int cycles = 0;
   // open drain data line with pull-up
   assign smbdat_in = sda_drv & ~smbdat_oe;
   always #5 clk = ~clk;
   clock_gear_output_control clock_gear_output_control_inst (.*);
   smbus_host_model smbus_host_model_inst (.clk(clk), .sda_line(smbdat_in),
      .smbclk_in(smbclk_in), .sda_drv(sda_drv));
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction
   // reference divider table, code 15 in the top nibble
   function automatic logic [6:0] gear_of(input logic [3:0] c, input logic f);
      logic [63:0] mt;
      logic [63:0] nt;
      mt = 64'h1323_4516_4385_2c53;
      nt = 64'h2534_5615_3253_1521;
      if (f && c == 4'h7)
         return {4'h5, 3'h4};
      return {mt[4*c+:4], nt[4*c+:3]};
   endfunction
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // changes seen on pair 0 over 400 cycles
   task automatic count_toggles(output int t);
      logic p;
      t = 0;
      p = diff_clock_pair[0];
      repeat (400)
      begin
         step(1);
         if (diff_clock_pair[0] !== p)
            t++;
         p = diff_clock_pair[0];
      end
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic stop_test();
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // hang guard, about three times the expected run
   always @(posedge clk)
   begin
      cycles++;
      if (cycles > 60000)
      begin
         n_mismatch++;
         stop_test();
      end
   end
   initial
   begin
      step(8);
      chk({gear_m, gear_n}, {4'h1, 3'h1});
      chk(config_ready, 0);
      rst = 1'b0;
      powergood_powerdown_pin = 1'b0;
      step(6);
      chk(config_ready, 1);
      chk({gear_m, gear_n}, gear_of(4'h9, 1'b0));
      for (int i = 0; i < 20; i++)
      begin
         seed = xs(seed);
         {upper_pairs_enable_n, pair9_enable_n, pair8_enable_n, pair7_enable_n,
            pair6_enable_n, pairs0_5_enable_n} = seed[10:0];
         step(6);
         chk(pair_drive, {~seed[10], ~seed[10:0]});
      end
      for (int b = 0; b < 2; b++)
      begin
         bypass_mode_addr_pin = b[0];
         step(6);
         chk({zero_delay_mode, pll_run}, {b[0], b[0]});
      end
      bypass_mode_addr_pin = 1'b0;
      step(6);
      for (int c = 0; c < 16; c++)
      begin
         seed = xs(seed);
         freq_range_select = 1'b0;
         smbus_host_model_inst.write_gear(8'hd0, {seed[7:4], c[3:0]}, ack);
         chk(ack, 1);
         for (int f = 0; f < 2; f++)
         begin
            freq_range_select = f[0];
            step(6);
            chk({gear_m, gear_n}, gear_of(c[3:0], f[0]));
         end
      end
      bypass_mode_addr_pin = 1'b1;
      step(6);
      smbus_host_model_inst.write_gear(8'hd0, 8'h03, ack);
      chk(ack, 0);
      chk({gear_m, gear_n}, gear_of(4'hf, 1'b1));
      wd = {seed[15:12], 4'h3};
      smbus_host_model_inst.write_gear(8'hd8, wd, ack);
      chk(ack, 1);
      chk({gear_m, gear_n}, gear_of(4'h3, 1'b1));
      smbus_host_model_inst.read_gear(8'hd8, cnt, rd);
      chk(cnt, 8'h01);
      chk(rd, wd);
      // window is a whole number of gear periods, so the count is exact
      {upper_pairs_enable_n, pair9_enable_n, pair8_enable_n, pair7_enable_n,
         pair6_enable_n, pairs0_5_enable_n} = 11'h000;
      {gm, gn} = gear_of(4'h3, 1'b1);
      step(6);
      count_toggles(tog);
      chk(tog, 400 * gn / (2 * gm));
      bypass_mode_addr_pin = 1'b0;
      step(6);
      count_toggles(tog);
      chk(tog, 200);
      powergood_powerdown_pin = 1'b1;
      step(10);
      chk({powered_down, config_ready, osc_run, pll_run}, 4'h8);
      step(4);
      chk(diff_clock_pair, 12'h000);
      stop_test();
   end
endmodule

/* test/gear_checker.sv */
// port assertions for the clock gear output control
`timescale 1ns/10ps
module gear_checker
(
   // system
   input wire logic clk,
   input wire logic rst,
   // pins
   input wire logic bypass_mode_addr_pin,
   input wire logic powergood_powerdown_pin,
   input wire logic [5:0] pairs0_5_enable_n,
   input wire logic pair6_enable_n,
   input wire logic pair7_enable_n,
   input wire logic pair8_enable_n,
   input wire logic pair9_enable_n,
   input wire logic upper_pairs_enable_n,
   // serial data
   input wire logic smbdat_out,
   input wire logic smbdat_oe,
   // outputs
   input wire logic [11:0] diff_clock_pair,
   input wire logic [11:0] pair_drive,
   input wire logic zero_delay_mode,
   input wire logic pll_run,
   input wire logic osc_run,
   input wire logic config_ready,
   input wire logic powered_down,
   input wire logic [3:0] gear_m,
   input wire logic [2:0] gear_n
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   wire logic [11:0] en_n = {upper_pairs_enable_n, upper_pairs_enable_n, pair9_enable_n,
      pair8_enable_n, pair7_enable_n, pair6_enable_n, pairs0_5_enable_n};
   // -----------------------------
   // sequences
   // -----------------------------
   sequence en_settled;
      (config_ready && $stable(en_n)) [*5];
   endsequence
   sequence pin_settled;
      $stable(bypass_mode_addr_pin) [*4];
   endsequence
   a_reset_gear_one: assert property ($fell(rst) |-> gear_m == 4'h1 && gear_n == 3'h1)
      else $error("gear not 1:1 after reset");
   a_data_low_only: assert property (smbdat_out == 1'b0)
      else $error("data line driven high");
   a_ready_after_good: assert property (!config_ready && !powered_down &&
      $fell(powergood_powerdown_pin) |-> ##[1:5] config_ready)
      else $error("ready missing after power good");
   a_power_down: assert property (config_ready && $rose(powergood_powerdown_pin) |->
      ##[1:8] (powered_down && !config_ready && !osc_run && !pll_run))
      else $error("power down not reached");
   a_idle_no_drive: assert property (!config_ready ##1 !config_ready |-> pair_drive == 12'h000)
      else $error("pairs driven while not ready");
   a_enable_follow: assert property (en_settled |-> pair_drive == ~en_n)
      else $error("pair drive differs from enables");
   a_upper_joint: assert property (pair_drive[10] == pair_drive[11])
      else $error("upper pairs split");
   a_tristate_quiet: assert property (
      (diff_clock_pair & ~pair_drive & ~$past(pair_drive)) == 12'h000)
      else $error("clock on tri-stated pair");
   a_mode_follow: assert property (pin_settled |-> zero_delay_mode == bypass_mode_addr_pin)
      else $error("mode differs from pin");
   a_pll_mode: assert property (pll_run == (config_ready && zero_delay_mode))
      else $error("pll run wrong");
   a_gear_nonzero: assert property (gear_m != 4'h0 && gear_n != 3'h0)
      else $error("zero divider");
endmodule
bind clock_gear_output_control gear_checker gear_checker_inst (.*);

/* test/smbus_host_model.sv */
// serial bus host model that drives the management pins
`timescale 1ns/10ps
module smbus_host_model
(
   // system
   input wire logic clk,
   // bus pins
   input wire logic sda_line,
   output logic smbclk_in,
   output logic sda_drv
);
   initial
   begin
      smbclk_in = 1'b1;
      sda_drv = 1'b1;
   end
   task automatic hold(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // data moves only with clock low, a few cycles clear of the fall
   task automatic bit_io(input logic b, output logic r);
      sda_drv = b;
      hold(10);
      smbclk_in = 1'b1;
      hold(10);
      r = sda_line;
      smbclk_in = 1'b0;
      hold(3);
   endtask
   task automatic start_bit();
      sda_drv = 1'b1;
      hold(10);
      smbclk_in = 1'b1;
      hold(10);
      sda_drv = 1'b0;
      hold(10);
      smbclk_in = 1'b0;
      hold(3);
   endtask
   task automatic stop_bit();
      sda_drv = 1'b0;
      hold(10);
      smbclk_in = 1'b1;
      hold(10);
      sda_drv = 1'b1;
      hold(10);
   endtask
   task automatic byte_out(input logic [7:0] b, output logic ok);
      logic r;
      for (int i = 7; i >= 0; i--)
         bit_io(b[i], r);
      bit_io(1'b1, r);
      ok = !r;
   endtask
   task automatic byte_in(input logic last, output logic [7:0] b);
      logic r;
      for (int i = 0; i < 8; i++)
      begin
         bit_io(1'b1, r);
         b = {b[6:0], r};
      end
      bit_io(last, r);
   endtask
   // index 0, count 1, one data byte
   task automatic write_gear(input logic [7:0] adr, input logic [7:0] d, output logic ok);
      logic [3:0] a;
      start_bit();
      byte_out(adr, a[0]);
      byte_out(8'h00, a[1]);
      byte_out(8'h01, a[2]);
      byte_out(d, a[3]);
      stop_bit();
      ok = &a;
   endtask
   task automatic read_gear(input logic [7:0] adr, output logic [7:0] cnt, output logic [7:0] d);
      logic a;
      start_bit();
      byte_out(adr, a);
      byte_out(8'h00, a);
      start_bit();
      byte_out(adr | 8'h01, a);
      byte_in(1'b0, cnt);
      byte_in(1'b1, d);
      stop_bit();
   endtask
endmodule
